// ---- led_indicator_load.sv ----
module led_indicator_load
(
  // design side of the pin
  input wire logic pinOut,
  input wire logic pinDrive_b,
  // outside driver, used only for input and enable modes
  input wire logic extDrive,
  input wire logic extLevel,
  // resolved wire level
  output logic pinLevel
);
  timeunit 1ns;
  timeprecision 1ns;

  // the design wins when it drives, then the outside driver; a line nobody drives rises through the pull-up
  always_comb
  begin
    if (!pinDrive_b)
      pinLevel = pinOut;
    else if (extDrive)
      pinLevel = extLevel;
    else
      pinLevel = 1'b1;
  end
endmodule : led_indicator_load

// ---- led_ramp_and_indicator_pin.sv ----
// What this block does
// R1 - brightness code drives exponential table, zero off
// R2 - ramp bits a,b select step interval
// R3 - code moves one per step interval
// R4 - first step of transition is immediate
// R5 - enabling ramps up from zero to target
// R6 - disable during rise ramps down to zero
// R7 - new target waits until current ramp ends
// R8 - rate change applies to remaining steps
// R9 - function bit zero makes pin enable input
// R10 - pattern mode with period selected by bits 7:6
// R11 - duty field selects pattern output fraction
// R12 - pattern spans 32 bit periods
// R13 - dead time high impedance after each pattern except at full duty
// R14 - duty code 111 latches pattern registers
// R15 - gpio input returns pin level in bit 2
// R16 - gpio output drives bit 2 level
// R17 - pattern shifts out least significant first
// R18 - pattern one pulls low, zero leaves open
// R19 - general bit 1 enables the main sink
// R20 - intervals counted from the single clock
// R21 - duty 000 is gpio, latch untouched
module led_ramp_and_indicator_pin
  import led_ramp_pkg::*;
#(
  parameter logic [TIMER_W-1:0] STEP0_CYCLES = TIMER_W'(STEP0_CYC),
  parameter logic [TIMER_W-1:0] STEP1_CYCLES = TIMER_W'(STEP1_CYC),
  parameter logic [TIMER_W-1:0] STEP2_CYCLES = TIMER_W'(STEP2_CYC),
  parameter logic [TIMER_W-1:0] STEP3_CYCLES = TIMER_W'(STEP3_CYC),
  parameter logic [TIMER_W-1:0] BIT0_CYCLES = TIMER_W'(BIT0_CYC),
  parameter logic [TIMER_W-1:0] BIT1_CYCLES = TIMER_W'(BIT1_CYC),
  parameter logic [TIMER_W-1:0] BIT2_CYCLES = TIMER_W'(BIT2_CYC),
  parameter logic [TIMER_W-1:0] BIT3_CYCLES = TIMER_W'(BIT3_CYC)
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [REG_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [REG_W-1:0] regRdData,
  // multi-function pin
  input wire logic pinIn,
  output logic pinOut,
  output logic pinDrive_b,
  // sink side
  output logic hardwareEnable,
  output logic [CODE_W-1:0] primaryBrightnessCode,
  output logic [CODE_W-1:0] secondaryBrightnessCode
);
  logic [REG_W-1:0] pinCtrl;
  logic [REG_W-1:0] general;
  logic [REG_W-1:0] patternReg [PATTERN_REGS];
  logic [CODE_W-1:0] targetMain;
  logic [CODE_W-1:0] targetSub;
  logic [PATTERN_BITS-1:0] latchedPattern;
  logic [PATTERN_BITS-1:0] patternWord;
  logic [TIMER_W-1:0] bitTimer;
  logic [SLOT_W-1:0] slot;
  logic pinLevel;
  pin_mode_type mode;
  logic [2:0] duty;
  logic [TIMER_W-1:0] stepCycles;
  logic [TIMER_W-1:0] bitCycles;
  logic ctrlWrite;
  logic latchWrite;
  logic bitDone;
  logic inPattern;

  assign duty = pinCtrl[CTRL_DUTY_MSB:CTRL_DUTY_LSB];
  assign ctrlWrite = regWrite && (regAddr == ADDR_PIN_CTRL);
  assign latchWrite = ctrlWrite && (regWrData[CTRL_DUTY_MSB:CTRL_DUTY_LSB] == DUTY_LATCH);
  assign patternWord = {patternReg[3], patternReg[2], patternReg[1], patternReg[0]};
  assign bitDone = (bitTimer >= bitCycles - 1'b1);
  assign inPattern = (slot < SLOT_W'(PATTERN_BITS));

  always_comb
  begin
    if (!pinCtrl[CTRL_FUNC_BIT])
      mode = MODE_ENABLE_IN; // R9
    else if (duty == DUTY_GPIO)
      mode = pinCtrl[CTRL_DIR_BIT] ? MODE_GPIO_IN : MODE_GPIO_OUT; // R21
    else
      mode = MODE_PATTERN; // R10
  end

  always_comb
  begin
    case ({general[GEN_RAMP_A_BIT], general[GEN_RAMP_B_BIT]})
      2'b00: stepCycles = STEP0_CYCLES; // R2
      2'b01: stepCycles = STEP1_CYCLES;
      2'b10: stepCycles = STEP2_CYCLES;
      default: stepCycles = STEP3_CYCLES;
    endcase
  end

  always_comb
  begin
    case (pinCtrl[CTRL_PERIOD_MSB:CTRL_PERIOD_LSB])
      2'b00: bitCycles = BIT0_CYCLES; // R10 R20
      2'b01: bitCycles = BIT1_CYCLES;
      2'b10: bitCycles = BIT2_CYCLES;
      default: bitCycles = BIT3_CYCLES;
    endcase
  end

  // latch code loads the pattern and takes the period and low bits; the duty setting in force is kept
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      pinCtrl <= PIN_CTRL_RESET;
    else if (latchWrite)
      pinCtrl <= {regWrData[CTRL_PERIOD_MSB:CTRL_PERIOD_LSB], duty, regWrData[CTRL_DATA_BIT:CTRL_FUNC_BIT]};
    else if (ctrlWrite)
      pinCtrl <= regWrData;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      latchedPattern <= '0;
    else if (latchWrite)
      latchedPattern <= patternWord; // R14
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      general <= GENERAL_RESET;
      targetMain <= CODE_ZERO;
      targetSub <= CODE_ZERO;
      for (int i = 0; i < PATTERN_REGS; i++)
        patternReg[i] <= PATTERN_RESET;
    end
    else if (regWrite)
    begin
      case (regAddr)
        ADDR_GENERAL: general <= regWrData;
        ADDR_BRIGHT_MAIN: targetMain <= regWrData[CODE_W-1:0];
        ADDR_BRIGHT_SUB: targetSub <= regWrData[CODE_W-1:0];
        ADDR_PATTERN0: patternReg[0] <= regWrData;
        ADDR_PATTERN1: patternReg[1] <= regWrData;
        ADDR_PATTERN2: patternReg[2] <= regWrData;
        ADDR_PATTERN3: patternReg[3] <= regWrData;
        default: general <= general;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pinLevel <= 1'b0;
      hardwareEnable <= 1'b0;
    end
    else
    begin
      pinLevel <= pinIn;
      hardwareEnable <= (mode == MODE_ENABLE_IN) ? pinIn : 1'b1; // R9
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      regRdData <= READ_ZERO;
    else if (regRead)
    begin
      case (regAddr)
        ADDR_PIN_CTRL:
          regRdData <= (mode == MODE_GPIO_IN) ? // R15
            {pinCtrl[CTRL_PERIOD_MSB:CTRL_DATA_BIT + 1], pinLevel, pinCtrl[CTRL_DIR_BIT:CTRL_FUNC_BIT]} :
            pinCtrl;
        ADDR_GENERAL: regRdData <= general;
        ADDR_BRIGHT_MAIN: regRdData <= {1'b0, targetMain};
        ADDR_BRIGHT_SUB: regRdData <= {1'b0, targetSub};
        ADDR_APPLIED_MAIN: regRdData <= {1'b0, primaryBrightnessCode};
        ADDR_APPLIED_SUB: regRdData <= {1'b0, secondaryBrightnessCode};
        ADDR_PATTERN0: regRdData <= patternReg[0];
        ADDR_PATTERN1: regRdData <= patternReg[1];
        ADDR_PATTERN2: regRdData <= patternReg[2];
        ADDR_PATTERN3: regRdData <= patternReg[3];
        default: regRdData <= READ_ZERO;
      endcase
    end
  end

  // frame of 32 pattern slots then dead slots, none at full duty; restarts on leaving pattern mode
  always_ff @(posedge clock)
  begin
    if (!rst_b || mode != MODE_PATTERN)
    begin
      bitTimer <= '0;
      slot <= '0;
    end
    else if (slot > lastSlot(duty))
    begin
      bitTimer <= '0;
      slot <= '0;
    end
    else if (bitDone)
    begin
      bitTimer <= '0;
      slot <= (slot == lastSlot(duty)) ? '0 : slot + 1'b1; // R11 R12 R13
    end
    else
      bitTimer <= bitTimer + 1'b1;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      pinOut <= 1'b0;
      pinDrive_b <= 1'b1;
    end
    else
    begin
      case (mode)
        MODE_PATTERN:
        begin
          pinOut <= 1'b0;
          pinDrive_b <= !(inPattern && latchedPattern[slot[4:0]]); // R17 R18 R13
        end
        MODE_GPIO_OUT:
        begin
          pinOut <= pinCtrl[CTRL_DATA_BIT]; // R16
          pinDrive_b <= 1'b0;
        end
        default:
        begin
          pinOut <= 1'b0;
          pinDrive_b <= 1'b1;
        end
      endcase
    end
  end

  ramp_channel #(.CW(CODE_W), .TW(TIMER_W)) mainRamp (
    .clock(clock),
    .rst_b(rst_b),
    .sinkEnable(general[GEN_MAIN_EN_BIT] && hardwareEnable), // R19 R5
    .targetCode(targetMain),
    .stepCycles(stepCycles),
    .appliedCode(primaryBrightnessCode)
  );

  ramp_channel #(.CW(CODE_W), .TW(TIMER_W)) subRamp (
    .clock(clock),
    .rst_b(rst_b),
    .sinkEnable(general[GEN_SUB_EN_BIT] && hardwareEnable),
    .targetCode(targetSub),
    .stepCycles(stepCycles),
    .appliedCode(secondaryBrightnessCode)
  );

  sequence seqLastPatternBit;
    (mode == MODE_PATTERN) && bitDone && (slot == SLOT_W'(PATTERN_BITS - 1));
  endsequence

  AST_ENABLE_IN_RELEASED: assert property (@(posedge clock) disable iff (!rst_b) // R9
    (mode == MODE_ENABLE_IN) |=> pinDrive_b)
    else $error("pin driven in enable-input mode");
  AST_PATTERN_ONE_LOW: assert property (@(posedge clock) disable iff (!rst_b) // R18
    (mode == MODE_PATTERN && inPattern && latchedPattern[slot[4:0]]) |=> (!pinDrive_b && !pinOut))
    else $error("pattern one did not pull pin low");
  AST_DEAD_TIME: assert property (@(posedge clock) disable iff (!rst_b) // R13
    (mode == MODE_PATTERN && !inPattern) |=> pinDrive_b)
    else $error("pin driven in dead time");
  AST_FULL_DUTY_WRAP: assert property (@(posedge clock) disable iff (!rst_b) // R12
    seqLastPatternBit ##0 (duty == DUTY_FULL) ##1 (mode == MODE_PATTERN) |-> (slot == '0))
    else $error("full duty pattern did not repeat after 32 bits");
  AST_LATCH_LOAD: assert property (@(posedge clock) disable iff (!rst_b) // R14
    latchWrite |=> (latchedPattern == $past(patternWord)) && (duty == $past(duty)))
    else $error("latch code did not load pattern");
  AST_LATCH_HELD: assert property (@(posedge clock) disable iff (!rst_b) // R21
    !latchWrite |=> $stable(latchedPattern))
    else $error("latched pattern changed without latch code");
  AST_GPIO_OUT: assert property (@(posedge clock) disable iff (!rst_b) // R16
    (mode == MODE_GPIO_OUT) |=> (!pinDrive_b && pinOut == $past(pinCtrl[CTRL_DATA_BIT])))
    else $error("gpio output level wrong");
  AST_GPIO_IN_READ: assert property (@(posedge clock) disable iff (!rst_b) // R15
    (regRead && regAddr == ADDR_PIN_CTRL && mode == MODE_GPIO_IN) |=>
      (regRdData[CTRL_DATA_BIT] == $past(pinLevel)) && pinDrive_b)
    else $error("gpio input read wrong");
  AST_BIT_PERIOD: assert property (@(posedge clock) disable iff (!rst_b) // R10
    (mode == MODE_PATTERN) && $stable(bitCycles) |-> (bitTimer < bitCycles))
    else $error("bit timer exceeded bit period");
endmodule : led_ramp_and_indicator_pin

// ---- led_ramp_pkg.sv ----
package led_ramp_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int CODE_W = 7;
  localparam int REG_W = 8;
  localparam int ADDR_W = 8;
  localparam int TIMER_W = 24;
  localparam int SLOT_W = 9;
  localparam int PATTERN_BITS = 32;
  localparam int PATTERN_REGS = 4;

  // step intervals, in ns, selected by ramp bits a,b
  localparam int STEP0_NS = 12750;
  localparam int STEP1_NS = 3250000;
  localparam int STEP2_NS = 6500000;
  localparam int STEP3_NS = 13000000;
  localparam int STEP0_CYC = (STEP0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP1_CYC = (STEP1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP2_CYC = (STEP2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP3_CYC = (STEP3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pattern bit periods, in ns
  localparam int BIT0_NS = 1600;
  localparam int BIT1_NS = 26000000;
  localparam int BIT2_NS = 52000000;
  localparam int BIT3_NS = 105000000;
  localparam int BIT0_CYC = (BIT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT1_CYC = (BIT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT2_CYC = (BIT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BIT3_CYC = (BIT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_GENERAL = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PIN_CTRL = 8'h80;
  localparam logic [ADDR_W-1:0] ADDR_PATTERN0 = 8'h90;
  localparam logic [ADDR_W-1:0] ADDR_PATTERN1 = 8'h91;
  localparam logic [ADDR_W-1:0] ADDR_PATTERN2 = 8'h92;
  localparam logic [ADDR_W-1:0] ADDR_PATTERN3 = 8'h93;
  localparam logic [ADDR_W-1:0] ADDR_BRIGHT_MAIN = 8'hA0;
  localparam logic [ADDR_W-1:0] ADDR_APPLIED_MAIN = 8'hA8;
  localparam logic [ADDR_W-1:0] ADDR_BRIGHT_SUB = 8'hB0;
  localparam logic [ADDR_W-1:0] ADDR_APPLIED_SUB = 8'hB8;

  localparam logic [REG_W-1:0] PIN_CTRL_RESET = 8'h01;
  localparam logic [REG_W-1:0] GENERAL_RESET = 8'h00;
  localparam logic [REG_W-1:0] PATTERN_RESET = 8'h00;
  localparam logic [CODE_W-1:0] CODE_ZERO = 7'h00;
  localparam logic [REG_W-1:0] READ_ZERO = 8'h00;

  // pin control fields
  localparam int CTRL_FUNC_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam int CTRL_DATA_BIT = 2;
  localparam int CTRL_DUTY_LSB = 3;
  localparam int CTRL_DUTY_MSB = 5;
  localparam int CTRL_PERIOD_LSB = 6;
  localparam int CTRL_PERIOD_MSB = 7;

  // general register fields
  localparam int GEN_MAIN_EN_BIT = 1;
  localparam int GEN_SUB_EN_BIT = 2;
  localparam int GEN_RAMP_B_BIT = 6;
  localparam int GEN_RAMP_A_BIT = 7;

  typedef enum logic [2:0] {
    DUTY_GPIO = 3'b000,
    DUTY_FULL = 3'b001,
    DUTY_HALF = 3'b010,
    DUTY_THIRD = 3'b011,
    DUTY_QUARTER = 3'b100,
    DUTY_SIXTH = 3'b101,
    DUTY_TWELFTH = 3'b110,
    DUTY_LATCH = 3'b111
  } duty_type;

  typedef enum logic [1:0] {
    MODE_ENABLE_IN = 2'b00,
    MODE_PATTERN = 2'b01,
    MODE_GPIO_IN = 2'b10,
    MODE_GPIO_OUT = 2'b11
  } pin_mode_type;

  // last slot of one frame: 32 pattern bits plus dead time, with no dead time at full duty
  function automatic logic [SLOT_W-1:0] lastSlot(input logic [2:0] duty);
    case (duty)
      DUTY_HALF: lastSlot = 9'h03F;
      DUTY_THIRD: lastSlot = 9'h05F;
      DUTY_QUARTER: lastSlot = 9'h07F;
      DUTY_SIXTH: lastSlot = 9'h0BF;
      DUTY_TWELFTH: lastSlot = 9'h17F;
      default: lastSlot = 9'h01F;
    endcase
  endfunction : lastSlot
endpackage : led_ramp_pkg

// ---- ramp_channel.sv ----
module ramp_channel
  import led_ramp_pkg::*;
#(
  parameter int CW = CODE_W,
  parameter int TW = TIMER_W
)
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // control
  input wire logic sinkEnable,
  input wire logic [CW-1:0] targetCode,
  input wire logic [TW-1:0] stepCycles,
  // applied code
  output logic [CW-1:0] appliedCode
);
  logic [CW-1:0] goal;
  logic [TW-1:0] timer;
  logic idle;
  logic stepNow;

  assign idle = (appliedCode == goal);
  assign stepNow = !idle && (timer == '0);

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      goal <= CODE_ZERO;
    else if (!sinkEnable)
      goal <= CODE_ZERO; // R6
    else if (idle)
      goal <= targetCode; // R7
  end

  // code feeds the exponential current table; zero means no current
  always_ff @(posedge clock)
  begin
    if (!rst_b)
      appliedCode <= CODE_ZERO;
    else if (stepNow)
      appliedCode <= (goal > appliedCode) ? appliedCode + 1'b1 : appliedCode - 1'b1; // R3 R5 R1
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
      timer <= '0;
    else if (idle)
      timer <= '0; // R4
    else if (stepNow)
      timer <= stepCycles - 1'b1; // R3 R20
    else if (timer >= stepCycles)
      timer <= stepCycles - 1'b1; // R8
    else
      timer <= timer - 1'b1;
  end

  sequence seqStartMove;
    idle ##1 !idle;
  endsequence

  AST_ONE_CODE_STEP: assert property (@(posedge clock) disable iff (!rst_b) // R3
    (appliedCode != $past(appliedCode)) |->
      ((appliedCode - $past(appliedCode)) == 7'h01 || ($past(appliedCode) - appliedCode) == 7'h01))
    else $error("code moved by more than one");
  AST_HOLD_STEP: assert property (@(posedge clock) disable iff (!rst_b) // R3
    (timer != '0) |=> $stable(appliedCode))
    else $error("code changed before step interval ended");
  AST_FIRST_STEP_NOW: assert property (@(posedge clock) disable iff (!rst_b) // R4
    seqStartMove |=> (appliedCode != $past(appliedCode)))
    else $error("first step was delayed");
  AST_STOP_RISING: assert property (@(posedge clock) disable iff (!rst_b) // R6
    !sinkEnable |=> (goal == CODE_ZERO))
    else $error("ramp kept rising after disable");
  AST_RATE_APPLIED: assert property (@(posedge clock) disable iff (!rst_b) // R8
    stepNow |=> (timer == $past(stepCycles) - 1'b1))
    else $error("step interval not reloaded from current rate");
endmodule : ramp_channel

// ---- tb.sv ----
module tb
  import led_ramp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int STEP_C[4] = '{4, 8, 12, 16};
  localparam int BIT_C[4] = '{4, 6, 8, 10};
  localparam int MULT[7] = '{0, 1, 2, 3, 4, 6, 12};

  typedef struct {logic [CODE_W-1:0] code; int gap;} code_note_type;

  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [REG_W-1:0] regWrData = '0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [REG_W-1:0] regRdData;
  logic pinLevel, pinOut, pinDrive_b, hardwareEnable;
  logic [CODE_W-1:0] primaryBrightnessCode, secondaryBrightnessCode;
  logic extDrive = 1'b0;
  logic extLevel = 1'b0;
  logic pinStrobe = 1'b0;
  logic readPend = 1'b0;
  logic [CODE_W-1:0] lastCode = '0;
  int gapCnt = 0;
  int cycles = 0;
  int failures = 0;
  int n_tests = 0;
  code_note_type codeQ[$];
  logic [REG_W-1:0] readQ[$];
  logic [2:0] pinQ[$];

  always #25 clock = ~clock;

  led_ramp_and_indicator_pin #(
    .STEP0_CYCLES(TIMER_W'(STEP_C[0])), .STEP1_CYCLES(TIMER_W'(STEP_C[1])),
    .STEP2_CYCLES(TIMER_W'(STEP_C[2])), .STEP3_CYCLES(TIMER_W'(STEP_C[3])),
    .BIT0_CYCLES(TIMER_W'(BIT_C[0])), .BIT1_CYCLES(TIMER_W'(BIT_C[1])),
    .BIT2_CYCLES(TIMER_W'(BIT_C[2])), .BIT3_CYCLES(TIMER_W'(BIT_C[3]))
  ) dut (
    .clock(clock), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pinIn(pinLevel),
    .pinOut(pinOut), .pinDrive_b(pinDrive_b), .hardwareEnable(hardwareEnable),
    .primaryBrightnessCode(primaryBrightnessCode), .secondaryBrightnessCode(secondaryBrightnessCode)
  );

  led_indicator_load load (
    .pinOut(pinOut), .pinDrive_b(pinDrive_b), .extDrive(extDrive), .extLevel(extLevel),
    .pinLevel(pinLevel)
  );

  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task report(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : report

  task chk_code(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
    report(32'(got), 32'(exp));
  endtask : chk_code

  task chk_gap(input int got, input int exp);
    report(got, exp);
  endtask : chk_gap

  task chk_read(input logic [REG_W-1:0] got, input logic [REG_W-1:0] exp);
    report(32'(got), 32'(exp));
  endtask : chk_read

  task chk_pin(input logic [2:0] got, input logic [2:0] exp);
    report(32'(got), 32'(exp));
  endtask : chk_pin

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    readQ.push_back(exp);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
  endtask : rd

  // pin result is {release, wire level, enable output}
  task pin_chk(input logic [2:0] exp);
    pinQ.push_back(exp);
    pinStrobe <= 1'b1;
    @(posedge clock);
    pinStrobe <= 1'b0;
  endtask : pin_chk

  task exp_ramp(input int from, input int to, input int gap);
    int c;
    int g;
    c = from;
    g = 0;
    while (c != to)
    begin
      c += (to > c) ? 1 : -1;
      codeQ.push_back('{code: c[CODE_W-1:0], gap: g});
      g = gap;
    end
  endtask : exp_ramp

  task wait_code(input int v);
    while (primaryBrightnessCode !== v[CODE_W-1:0])
      @(posedge clock);
  endtask : wait_code

  task wait_q;
    while (codeQ.size() != 0)
      @(posedge clock);
    repeat (2) @(posedge clock);
  endtask : wait_q

  function automatic logic [7:0] gen_val(input int r, input bit m, input bit s);
    return {r[1], r[0], 3'b000, s, m, 1'b0};
  endfunction : gen_val

  // watcher: every code change, read answer and pin sample takes the oldest note
  always @(posedge clock)
  begin
    code_note_type note;
    gapCnt++;
    if (rst_b && primaryBrightnessCode !== lastCode)
    begin
      if (codeQ.size() == 0)
        chk_code(primaryBrightnessCode, lastCode);
      else
      begin
        note = codeQ.pop_front();
        chk_code(primaryBrightnessCode, note.code);
        if (note.gap != 0)
          chk_gap(gapCnt, note.gap);
      end
      gapCnt = 0;
      lastCode = primaryBrightnessCode;
    end
    if (readPend)
      chk_read(regRdData, readQ.pop_front());
    readPend = regRead;
    if (pinStrobe)
      chk_pin({pinDrive_b, pinLevel, hardwareEnable}, pinQ.pop_front());
  end

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      end_sim();
    end
  end

  initial
  begin
    int n;
    int p;
    int bc;
    int frame;
    logic [31:0] word;
    logic [31:0] pat;
    pat = '0;
    void'($urandom(83579));
    repeat (6) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h80, 8'h01);
    rd(8'h55, 8'h00);
    rd(8'h10, 8'h00);
    rd(8'h90, 8'h00);
    pin_chk(3'b001);
    // rise at rate 01, then fall
    exp_ramp(0, 5, STEP_C[1]);
    wr(8'hA0, 8'h05);
    wr(8'h10, gen_val(1, 1, 0));
    n = 0;
    while (primaryBrightnessCode === CODE_ZERO && n < 10)
    begin
      @(posedge clock);
      n++;
    end
    chk_gap(int'(n <= 4), 1);
    wait_q();
    wr(8'hA8, 8'h7F);
    rd(8'hA8, 8'h05);
    exp_ramp(5, 0, STEP_C[1]);
    wr(8'h10, gen_val(1, 0, 0));
    wait_q();
    // disable during rise at rate 10
    exp_ramp(0, 3, STEP_C[2]);
    exp_ramp(3, 0, STEP_C[2]);
    wr(8'hA0, 8'h7F);
    wr(8'h10, gen_val(2, 1, 0));
    wait_code(3);
    wr(8'h10, gen_val(2, 0, 0));
    wait_q();
    // new target mid-ramp at rate 00
    exp_ramp(0, 16, STEP_C[0]);
    exp_ramp(16, 8, STEP_C[0]);
    wr(8'hA0, 8'h10);
    wr(8'h10, gen_val(0, 1, 0));
    wait_code(3);
    wr(8'hA0, 8'h08);
    wait_q();
    exp_ramp(8, 0, STEP_C[0]);
    wr(8'h10, gen_val(0, 0, 0));
    wait_q();
    // rate change mid-ramp, secondary sink alongside
    wr(8'hB0, 8'h83);
    rd(8'hB0, 8'h03);
    exp_ramp(0, 3, STEP_C[3]);
    exp_ramp(3, 10, STEP_C[0]);
    wr(8'hA0, 8'h0A);
    wr(8'h10, gen_val(3, 1, 1));
    wait_code(3);
    wr(8'h10, gen_val(0, 1, 1));
    wait_q();
    rd(8'hB8, 8'h03);
    exp_ramp(10, 0, STEP_C[0]);
    wr(8'h10, gen_val(0, 0, 0));
    wait_q();
    rd(8'hB8, 8'h00);
    // general purpose output and input
    wr(8'h80, 8'h05);
    repeat (3) @(posedge clock);
    pin_chk(3'b011);
    extDrive <= 1'b1;
    wr(8'h80, 8'h03);
    repeat (4) @(posedge clock);
    rd(8'h80, 8'h03);
    extLevel <= 1'b1;
    repeat (4) @(posedge clock);
    rd(8'h80, 8'h07);
    pin_chk(3'b111);
    // enable input mode ignores upper bits
    wr(8'h80, 8'hF8);
    repeat (3) @(posedge clock);
    pin_chk(3'b111);
    extLevel <= 1'b0;
    repeat (3) @(posedge clock);
    pin_chk(3'b100);
    extDrive <= 1'b0;
    // pattern output over every duty and period
    for (int d = 1; d <= 6; d++)
    begin
      p = d % 4;
      bc = BIT_C[p];
      frame = 32 * MULT[d];
      word = $urandom();
      wr(8'h80, 8'h01);
      for (int i = 0; i < 4; i++)
        wr(8'h90 + 8'(i), word[8*i +: 8]);
      if (d % 2 == 1)
      begin
        wr(8'h80, {p[1:0], 3'b111, 3'b001});
        pat = word;
      end
      wr(8'h80, {p[1:0], d[2:0], 3'b001});
      repeat (1 + bc / 2) @(posedge clock);
      for (int s = 0; s < frame + 32; s++)
      begin
        pin_chk(((s % frame) < 32 && pat[s % frame]) ? 3'b001 : 3'b111);
        repeat (bc - 1) @(posedge clock);
      end
    end
    wr(8'h80, 8'h01);
    repeat (4) @(posedge clock);
    end_sim();
  end
endmodule : tb
